/* File: logic/clrp_port_top.sv */
`timescale 1ns/100ps
// Overview of operation
// - The first and second counter outputs drive level outputs and rising-edge pulses for update strobes or interrupts.
// - The third counter's output can replace the timebase as the clock of the first and second counters.
// - Each data port is one byte wide and a sixteen-bit count moves as two successive byte accesses on one port.
// - A write to a data port loads the byte or bytes into that counter as its starting count.
// - A read of a data port returns the live count when nothing is latched and the latched data otherwise.
// - A single-counter latch command or a read-back command captures a counter's count or status for reading.
// - Latched data stays frozen while counting continues until the host has read all of it or reprograms that counter.
// - While latched data is unread, later latch requests of the same kind for that counter are ignored.
// - A latched sixteen-bit count reads low byte first and high byte second.
// - With status and count both latched, the status byte reads first and the count bytes follow.
// - The first counter's port decodes at offset 06 only while the group two write select bit is clear.
// - The second counter's port decodes at offset 07 only while the group two write select bit is clear.
// - The command's two top bits pick counter one, two or three, or turn the byte into a read-back command.
// - The command's byte access field picks latch, low byte only, high byte only, or low then high byte.
// - The command's lowest bit selects decimal counting when set and sixteen-bit binary when clear.
module clrp_port_top
  import clrp_pkg::*;
(
  input  wire logic              I_CLK_SYS,
  input  wire logic              I_RST,
  input  wire logic              I_CE,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic              I_WR_STB,
  input  wire logic              I_RD_STB,
  input  wire logic [7:0]        I_WDATA,
  input  wire logic              I_GROUP_TWO_WRITE_SELECT,
  input  wire logic              I_ALT_CLOCK_SELECT,
  input  wire logic              I_TIMEBASE,
  output logic      [7:0]        O_RDATA,
  output logic      [1:0]        O_COUNTER_OUT,
  output logic      [1:0]        O_UPDATE_STROBE
);

  ////////////////////////////////////////////////////////////////////////////
  // Timebase synchroniser and tick generation.
  logic       tb_meta_reg, tb_meta_next;
  logic       tb_sync_reg, tb_sync_next;
  logic       tb_prev_reg, tb_prev_next;
  logic       c3_prev_reg, c3_prev_next;
  logic       tb_tick;
  logic       c3_tick;
  logic [NUM_CNT-1:0] tick;

  // Per-counter host-side state.
  clrp_cmd_t    cfg_reg [NUM_CNT];
  clrp_cmd_t    cfg_next [NUM_CNT];
  logic [7:0]   lo_byte_reg [NUM_CNT];
  logic [7:0]   lo_byte_next [NUM_CNT];
  logic [15:0]  cnt_lat_reg [NUM_CNT];
  logic [15:0]  cnt_lat_next [NUM_CNT];
  logic [7:0]   st_lat_reg [NUM_CNT];
  logic [7:0]   st_lat_next [NUM_CNT];
  logic [NUM_CNT-1:0] wr_hi_reg, wr_hi_next;
  logic [NUM_CNT-1:0] rd_hi_reg, rd_hi_next;
  logic [NUM_CNT-1:0] lat_hi_reg, lat_hi_next;
  logic [NUM_CNT-1:0] cnt_held_reg, cnt_held_next;
  logic [NUM_CNT-1:0] st_held_reg, st_held_next;

  // Decoded strobes and counter element signals.
  logic [NUM_CNT-1:0] port_hit;
  logic [NUM_CNT-1:0] program_stb;
  logic [NUM_CNT-1:0] latch_cnt;
  logic [NUM_CNT-1:0] latch_st;
  logic [NUM_CNT-1:0] load_stb;
  logic [15:0]        load_val [NUM_CNT];
  logic [15:0]        live_cnt [NUM_CNT];
  logic [NUM_CNT-1:0] null_cnt;
  logic [NUM_CNT-1:0] cnt_out;
  clrp_cmd_t          cmd_in;
  logic [7:0]         port_byte [NUM_CNT];

  // Output registers.
  logic [7:0] rdata_reg, rdata_next;
  logic [1:0] out_reg, out_next;
  logic [1:0] strobe_reg, strobe_next;

  ////////////////////////////////////////////////////////////////////////////
  // The timebase pin is asynchronous, so only the second stage feeds the edge detector.
  always_comb begin
    tb_meta_next = I_TIMEBASE;
    tb_sync_next = tb_meta_reg;
    tb_prev_next = tb_sync_reg;
    c3_prev_next = cnt_out[2];
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      tb_meta_reg <= 1'b0;
      tb_sync_reg <= 1'b0;
      tb_prev_reg <= 1'b0;
      c3_prev_reg <= 1'b1;
    end else if (I_CE) begin
      tb_meta_reg <= tb_meta_next;
      tb_sync_reg <= tb_sync_next;
      tb_prev_reg <= tb_prev_next;
      c3_prev_reg <= c3_prev_next;
    end
  end

  // Counters one and two run from the timebase or from the third counter's rising output.
  assign tb_tick = tb_sync_reg & ~tb_prev_reg;
  assign c3_tick = cnt_out[2] & ~c3_prev_reg;
  assign tick[0] = I_ALT_CLOCK_SELECT ? c3_tick : tb_tick;
  assign tick[1] = I_ALT_CLOCK_SELECT ? c3_tick : tb_tick;
  assign tick[2] = tb_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode. The two lower data ports share offsets with the second register
  // group, so they answer only while that group is deselected.
  assign cmd_in      = clrp_cmd_t'(I_WDATA);
  assign port_hit[0] = (I_ADDR == OFS_CNT1) && !I_GROUP_TWO_WRITE_SELECT;
  assign port_hit[1] = (I_ADDR == OFS_CNT2) && !I_GROUP_TWO_WRITE_SELECT;
  assign port_hit[2] = (I_ADDR == OFS_CNT3);

  always_comb begin
    program_stb = '0;
    latch_cnt   = '0;
    latch_st    = '0;
    if (I_WR_STB && I_ADDR == OFS_CMD) begin
      if (cmd_in.sel == SEL_RDBK) begin
        for (int i = 0; i < NUM_CNT; i++) begin
          latch_cnt[i] = I_WDATA[RB_SEL_LSB + i] & ~I_WDATA[RB_NCOUNT_BIT];
          latch_st[i]  = I_WDATA[RB_SEL_LSB + i] & ~I_WDATA[RB_NSTATUS_BIT];
        end
      end else if (cmd_in.rw == RW_LATCH) begin
        latch_cnt[cmd_in.sel] = 1'b1;
      end else begin
        program_stb[cmd_in.sel] = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Byte sequencing, latches and read data for all three ports.
  always_comb begin
    wr_hi_next    = wr_hi_reg;
    rd_hi_next    = rd_hi_reg;
    lat_hi_next   = lat_hi_reg;
    cnt_held_next = cnt_held_reg;
    st_held_next  = st_held_reg;
    load_stb      = '0;
    rdata_next    = rdata_reg;
    for (int i = 0; i < NUM_CNT; i++) begin
      cfg_next[i]     = cfg_reg[i];
      lo_byte_next[i] = lo_byte_reg[i];
      cnt_lat_next[i] = cnt_lat_reg[i];
      st_lat_next[i]  = st_lat_reg[i];
      load_val[i]     = {BYTE_ZERO, I_WDATA};
      // Byte presented on a read: status, then latched count, then live count.
      if (st_held_reg[i]) begin
        port_byte[i] = st_lat_reg[i];
      end else if (cnt_held_reg[i]) begin
        port_byte[i] = (cfg_reg[i].rw == RW_HIGH || (cfg_reg[i].rw == RW_BOTH && lat_hi_reg[i]))
                       ? cnt_lat_reg[i][15:8] : cnt_lat_reg[i][7:0];
      end else begin
        port_byte[i] = (cfg_reg[i].rw == RW_HIGH || (cfg_reg[i].rw == RW_BOTH && rd_hi_reg[i]))
                       ? live_cnt[i][15:8] : live_cnt[i][7:0];
      end
      if (program_stb[i]) begin
        cfg_next[i]     = cmd_in;
        wr_hi_next[i]   = 1'b0;
        rd_hi_next[i]   = 1'b0;
        lat_hi_next[i]  = 1'b0;
        cnt_held_next[i] = 1'b0;
        st_held_next[i]  = 1'b0;
      end
      if (I_WR_STB && port_hit[i]) begin
        unique case (cfg_reg[i].rw)
          RW_HIGH: begin
            load_stb[i] = 1'b1;
            load_val[i] = {I_WDATA, BYTE_ZERO};
          end
          RW_BOTH: begin
            if (wr_hi_reg[i]) begin
              load_stb[i] = 1'b1;
              load_val[i] = {I_WDATA, lo_byte_reg[i]};
            end else begin
              lo_byte_next[i] = I_WDATA;
            end
            wr_hi_next[i] = ~wr_hi_reg[i];
          end
          default: load_stb[i] = 1'b1;
        endcase
      end
      if (I_RD_STB && port_hit[i]) begin
        rdata_next = port_byte[i];
        // Latched data is released once every byte of it has been read, or at once when that counter is reprogrammed.
        if (st_held_reg[i]) begin
          st_held_next[i] = 1'b0;
        end else if (cnt_held_reg[i]) begin
          if (cfg_reg[i].rw == RW_BOTH && !lat_hi_reg[i]) begin
            lat_hi_next[i] = 1'b1;
          end else begin
            lat_hi_next[i]   = 1'b0;
            cnt_held_next[i] = 1'b0;
          end
        end else if (cfg_reg[i].rw == RW_BOTH) begin
          rd_hi_next[i] = ~rd_hi_reg[i];
        end
      end
      // Capture is gated on the registered held flag, so a latch arriving with the last read byte is dropped.
      if (latch_cnt[i] && !cnt_held_reg[i]) begin
        cnt_lat_next[i]  = live_cnt[i];
        cnt_held_next[i] = 1'b1;
        lat_hi_next[i]   = 1'b0;
      end
      if (latch_st[i] && !st_held_reg[i]) begin
        st_lat_next[i]  = clrp_status_t'({cnt_out[i], null_cnt[i], cfg_reg[i].rw,
                                          cfg_reg[i].mode, cfg_reg[i].bcd});
        st_held_next[i] = 1'b1;
      end
    end
    if (I_RD_STB && !(|port_hit)) begin
      rdata_next = BYTE_ZERO;
    end
  end

  // Host-side registers.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      wr_hi_reg    <= '0;
      rd_hi_reg    <= '0;
      lat_hi_reg   <= '0;
      cnt_held_reg <= '0;
      st_held_reg  <= '0;
      rdata_reg    <= BYTE_ZERO;
      for (int i = 0; i < NUM_CNT; i++) begin
        cfg_reg[i]     <= CMD_RST;
        lo_byte_reg[i] <= BYTE_ZERO;
        cnt_lat_reg[i] <= COUNT_RST;
        st_lat_reg[i]  <= BYTE_ZERO;
      end
    end else if (I_CE) begin
      wr_hi_reg    <= wr_hi_next;
      rd_hi_reg    <= rd_hi_next;
      lat_hi_reg   <= lat_hi_next;
      cnt_held_reg <= cnt_held_next;
      st_held_reg  <= st_held_next;
      rdata_reg    <= rdata_next;
      for (int i = 0; i < NUM_CNT; i++) begin
        cfg_reg[i]     <= cfg_next[i];
        lo_byte_reg[i] <= lo_byte_next[i];
        cnt_lat_reg[i] <= cnt_lat_next[i];
        st_lat_reg[i]  <= st_lat_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // The three counting elements.
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    clrp_counter_unit u_unit (
      .i_clk      (I_CLK_SYS),
      .i_rst      (I_RST),
      .i_ce       (I_CE),
      .i_tick     (tick[g]),
      .i_program  (program_stb[g]),
      .i_mode     (cfg_reg[g].mode),
      .i_bcd      (cfg_reg[g].bcd),
      .i_load_stb (load_stb[g]),
      .i_load_val (load_val[g]),
      .o_count    (live_cnt[g]),
      .o_null     (null_cnt[g]),
      .o_out      (cnt_out[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output stage. Strobes are one cycle long so an update or interrupt source sees a clean edge.
  always_comb begin
    out_next    = cnt_out[1:0];
    strobe_next = cnt_out[1:0] & ~out_reg;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      out_reg    <= 2'h3;
      strobe_reg <= 2'h0;
    end else if (I_CE) begin
      out_reg    <= out_next;
      strobe_reg <= strobe_next;
    end
  end

  assign O_RDATA         = rdata_reg;
  assign O_COUNTER_OUT   = out_reg;
  assign O_UPDATE_STROBE = strobe_reg;

endmodule : clrp_port_top

/* File: logic/clrp_pkg.sv */
package clrp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Host port map, offsets relative to the board base address.
  localparam int           ADDR_W   = 4;
  localparam logic [3:0]   OFS_CNT1 = 4'h6;
  localparam logic [3:0]   OFS_CNT2 = 4'h7;
  localparam logic [3:0]   OFS_CNT3 = 4'h8;
  localparam logic [3:0]   OFS_CMD  = 4'h9;
  localparam int           NUM_CNT  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Command byte field codes.
  localparam logic [1:0]   SEL_C1   = 2'h0;
  localparam logic [1:0]   SEL_C2   = 2'h1;
  localparam logic [1:0]   SEL_C3   = 2'h2;
  localparam logic [1:0]   SEL_RDBK = 2'h3;
  localparam logic [1:0]   RW_LATCH = 2'h0;
  localparam logic [1:0]   RW_LOW   = 2'h1;
  localparam logic [1:0]   RW_HIGH  = 2'h2;
  localparam logic [1:0]   RW_BOTH  = 2'h3;
  localparam logic [2:0]   MODE_TERM_INT  = 3'h0;
  localparam logic [2:0]   MODE_ONE_SHOT  = 3'h1;
  localparam logic [2:0]   MODE_RATE      = 3'h2;
  localparam logic [2:0]   MODE_SQUARE    = 3'h3;
  localparam logic [2:0]   MODE_SW_STROBE = 3'h4;
  localparam logic [2:0]   MODE_HW_STROBE = 3'h5;

  // Read-back command bits; both latch flags are active low.
  localparam int           RB_NCOUNT_BIT  = 5;
  localparam int           RB_NSTATUS_BIT = 4;
  localparam int           RB_SEL_LSB     = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic [1:0] sel;
    logic [1:0] rw;
    logic [2:0] mode;
    logic       bcd;
  } clrp_cmd_t;

  typedef struct packed {
    logic       out;
    logic       null_cnt;
    logic [1:0] rw;
    logic [2:0] mode;
    logic       bcd;
  } clrp_status_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and count constants.
  localparam clrp_cmd_t    CMD_RST    = '{sel: SEL_C1, rw: RW_LOW, mode: MODE_TERM_INT, bcd: 1'b0};
  localparam logic [15:0]  COUNT_RST  = 16'h0000;
  localparam logic [15:0]  CNT_ONE    = 16'h0001;
  localparam logic [15:0]  CNT_TWO    = 16'h0002;
  localparam logic [7:0]   BYTE_ZERO  = 8'h00;

endpackage : clrp_pkg

/* File: logic/clrp_counter_unit.sv */
`timescale 1ns/100ps
module clrp_counter_unit
  import clrp_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_ce,
  input  wire logic        i_tick,
  input  wire logic        i_program,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_bcd,
  input  wire logic        i_load_stb,
  input  wire logic [15:0] i_load_val,
  output logic      [15:0] o_count,
  output logic             o_null,
  output logic             o_out
);

  logic [15:0] count_reg, count_next;
  logic [15:0] load_reg, load_next;
  logic        armed_reg, armed_next;
  logic        running_reg, running_next;
  logic        null_reg, null_next;
  logic        out_reg, out_next;
  logic [15:0] dec_val;

  ////////////////////////////////////////////////////////////////////////////
  // Decimal decrement, digit by digit; zero wraps to the largest value.
  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    for (int d = 0; d < 4; d++) begin
      if (borrow) begin
        if (r[d*4 +: 4] == 4'h0) begin
          r[d*4 +: 4] = 4'h9;
        end else begin
          r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
          borrow      = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec

  ////////////////////////////////////////////////////////////////////////////
  // Counting element. A new starting count takes effect on the next tick, so the
  // host can write both bytes without the counter running on a half value.
  always_comb begin
    count_next   = count_reg;
    load_next    = load_reg;
    armed_next   = armed_reg;
    running_next = running_reg;
    null_next    = null_reg;
    out_next     = out_reg;
    dec_val      = i_bcd ? bcd_dec(count_reg) : count_reg - CNT_ONE;
    if (i_program) begin
      armed_next   = 1'b0;
      running_next = 1'b0;
      null_next    = 1'b1;
      out_next     = 1'b1;
    end else if (i_load_stb) begin
      load_next  = i_load_val;
      armed_next = 1'b1;
      null_next  = 1'b1;
    end
    if (i_tick && !i_program) begin
      if (armed_reg) begin
        count_next   = load_reg;
        armed_next   = i_load_stb;
        running_next = 1'b1;
        null_next    = i_load_stb;
        if (i_mode == MODE_TERM_INT || i_mode == MODE_ONE_SHOT) begin
          out_next = 1'b0;
        end
      end else if (running_reg) begin
        // Periodic modes reload at one; square wave toggles there, so its period is twice the count.
        if ((i_mode == MODE_RATE || i_mode == MODE_SQUARE) && count_reg == CNT_ONE) begin
          count_next = load_reg;
          out_next   = (i_mode == MODE_SQUARE) ? ~out_reg : 1'b1;
        end else begin
          count_next = dec_val;
          if (i_mode == MODE_TERM_INT || i_mode == MODE_ONE_SHOT) begin
            out_next = out_reg | (count_reg == CNT_ONE);
          end else if (i_mode != MODE_SQUARE) begin
            out_next = (count_reg != CNT_TWO);
          end
        end
      end
    end
  end

  // State registers; all frozen while the clock enable is low.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_reg   <= COUNT_RST;
      load_reg    <= COUNT_RST;
      armed_reg   <= 1'b0;
      running_reg <= 1'b0;
      null_reg    <= 1'b1;
      out_reg     <= 1'b1;
    end else if (i_ce) begin
      count_reg   <= count_next;
      load_reg    <= load_next;
      armed_reg   <= armed_next;
      running_reg <= running_next;
      null_reg    <= null_next;
      out_reg     <= out_next;
    end
  end

  assign o_count = count_reg;
  assign o_null  = null_reg;
  assign o_out   = out_reg;

endmodule : clrp_counter_unit

/* File: dv/clrp_port_top_asserts.sv */
`timescale 1ns/100ps
module clrp_port_top_asserts
  import clrp_pkg::*;
(
  input wire logic              I_CLK_SYS,
  input wire logic              I_RST,
  input wire logic              I_CE,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic              I_WR_STB,
  input wire logic              I_RD_STB,
  input wire logic [7:0]        I_WDATA,
  input wire logic              I_GROUP_TWO_WRITE_SELECT,
  input wire logic              I_ALT_CLOCK_SELECT,
  input wire logic              I_TIMEBASE,
  input wire logic [7:0]        O_RDATA,
  input wire logic [1:0]        O_COUNTER_OUT,
  input wire logic [1:0]        O_UPDATE_STROBE
);
  // Everything runs on the system clock and is quiet while reset is held.
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  ////////////////////////////////////////////////////////////////////////////
  // Read data moves only after a read, so a write or a tick never disturbs it.
  a_rdata_hold: assert property (!I_RD_STB && !$past(I_RD_STB) |=> $stable(O_RDATA))
    else $error("read data changed without a read");
  a_gate_first: assert property (I_CE && I_RD_STB && I_GROUP_TWO_WRITE_SELECT && I_ADDR == OFS_CNT1
    |=> O_RDATA == BYTE_ZERO) else $error("counter one port answered while group two selected");
  a_gate_second: assert property (I_CE && I_RD_STB && I_GROUP_TWO_WRITE_SELECT && I_ADDR == OFS_CNT2
    |=> O_RDATA == BYTE_ZERO) else $error("counter two port answered while group two selected");
  a_unmapped_zero: assert property (I_CE && I_RD_STB && I_ADDR != OFS_CNT1 && I_ADDR != OFS_CNT2
    && I_ADDR != OFS_CNT3 |=> O_RDATA == BYTE_ZERO) else $error("unmapped read gave data");

  ////////////////////////////////////////////////////////////////////////////
  // A strobe must follow a fresh rise of its counter output, one cycle wide.
  a_strobe_cause_one: assert property (O_UPDATE_STROBE[0] |-> O_COUNTER_OUT[0]
    && (!$past(O_COUNTER_OUT[0]) || !$past(O_COUNTER_OUT[0], 2))) else $error("strobe one without rise");
  a_strobe_cause_two: assert property (O_UPDATE_STROBE[1] |-> O_COUNTER_OUT[1]
    && (!$past(O_COUNTER_OUT[1]) || !$past(O_COUNTER_OUT[1], 2))) else $error("strobe two without rise");
  a_strobe_single: assert property (I_CE && O_UPDATE_STROBE != 2'b00
    |=> (O_UPDATE_STROBE & $past(O_UPDATE_STROBE)) == 2'b00) else $error("strobe longer than a cycle");
  // Clock enable low must freeze every visible output.
  a_ce_freeze: assert property (!I_CE |=> $stable(O_RDATA) && $stable(O_COUNTER_OUT) && $stable(O_UPDATE_STROBE))
    else $error("outputs moved with clock enable low");
endmodule : clrp_port_top_asserts

bind clrp_port_top clrp_port_top_asserts u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .I_CE(I_CE), .I_ADDR(I_ADDR),
  .I_WR_STB(I_WR_STB), .I_RD_STB(I_RD_STB), .I_WDATA(I_WDATA), .I_GROUP_TWO_WRITE_SELECT(I_GROUP_TWO_WRITE_SELECT),
  .I_ALT_CLOCK_SELECT(I_ALT_CLOCK_SELECT), .I_TIMEBASE(I_TIMEBASE), .O_RDATA(O_RDATA),
  .O_COUNTER_OUT(O_COUNTER_OUT), .O_UPDATE_STROBE(O_UPDATE_STROBE));

/* File: dv/clrp_host_model.sv */
`timescale 1ns/100ps
module clrp_host_model
  import clrp_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic [7:0]        i_rdata,
  output logic      [ADDR_W-1:0] o_addr,
  output logic                   o_wr_stb,
  output logic                   o_rd_stb,
  output logic      [7:0]        o_wdata
);
  // The bus starts idle with both strobes low.
  initial begin
    o_addr   = '0;
    o_wr_stb = 1'b0;
    o_rd_stb = 1'b0;
    o_wdata  = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One byte per strobe; released lines show the inverse so stale values never look live.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr   = a;
    o_wdata  = d;
    o_wr_stb = 1'b1;
    @(negedge i_clk);
    o_wr_stb = 1'b0;
    o_addr   = ~a;
    o_wdata  = ~d;
  endtask : wr

  // The answer is taken a full cycle after the strobe edge, where it still stands.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr   = a;
    o_rd_stb = 1'b1;
    @(negedge i_clk);
    o_rd_stb = 1'b0;
    o_addr   = ~a;
    @(negedge i_clk);
    d = i_rdata;
  endtask : rd
endmodule : clrp_host_model

/* File: dv/test_counter_load_readback_port.sv */
`timescale 1ns/100ps
module test_counter_load_readback_port
  import clrp_pkg::*;
;
  `define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin err_count++; \
    $display("Error at %0t: got %h expected %h", $time, (act), (exp)); end end

  typedef struct {logic [1:0] sel; logic bcd; logic [15:0] n; int tk; logic [15:0] e;} clrp_row_t;
  localparam int     LIMIT     = 20000;
  logic              clk_sys   = 1'b0;
  logic              rst       = 1'b1;
  logic              ce        = 1'b1;
  logic              grp_two   = 1'b0;
  logic              alt_sel   = 1'b0;
  logic              timebase  = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic              wr_stb;
  logic              rd_stb;
  logic [7:0]        wdata;
  logic [7:0]        rdata;
  logic [7:0]        lo;
  logic [7:0]        hi;
  logic [1:0]        cnt_out;
  logic [1:0]        upd;
  int                err_count = 0;
  int                checked   = 0;
  int                cycles    = 0;
  int                strobes[2] = '{0, 0};
  int                base[2];
  // The first tick loads the count and every later tick takes one off it.
  clrp_row_t rows[4] = '{'{SEL_C1, 1'b0, 16'h0100, 3, 16'h00FE}, '{SEL_C2, 1'b1, 16'h0100, 3, 16'h0098},
                         '{SEL_C1, 1'b1, 16'h1000, 2, 16'h0999}, '{SEL_C2, 1'b0, 16'h1234, 4, 16'h1231}};

  clrp_host_model host (.i_clk(clk_sys), .i_rdata(rdata), .o_addr(addr), .o_wr_stb(wr_stb),
    .o_rd_stb(rd_stb), .o_wdata(wdata));
  clrp_port_top uut (.I_CLK_SYS(clk_sys), .I_RST(rst), .I_CE(ce), .I_ADDR(addr), .I_WR_STB(wr_stb),
    .I_RD_STB(rd_stb), .I_WDATA(wdata), .I_GROUP_TWO_WRITE_SELECT(grp_two), .I_ALT_CLOCK_SELECT(alt_sel),
    .I_TIMEBASE(timebase), .O_RDATA(rdata), .O_COUNTER_OUT(cnt_out), .O_UPDATE_STROBE(upd));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, strobe tally and the hang limit.
  always #5 clk_sys = ~clk_sys;
  // Strobes are tallied on the falling edge, where the registered pulse has settled.
  always @(negedge clk_sys) begin
    cycles++;
    if (upd[0] === 1'b1) strobes[0]++;
    if (upd[1] === 1'b1) strobes[1]++;
    if (cycles == LIMIT) begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [ADDR_W-1:0] port(input logic [1:0] sel);
    return (sel == SEL_C1) ? OFS_CNT1 : (sel == SEL_C2) ? OFS_CNT2 : OFS_CNT3;
  endfunction : port

  // Ticks are slow against the clock so the two-stage synchroniser always settles.
  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge clk_sys);
      timebase = 1'b1;
      repeat (3) @(negedge clk_sys);
      timebase = 1'b0;
      repeat (2) @(negedge clk_sys);
    end
    repeat (6) @(negedge clk_sys);
  endtask : ticks

  task automatic load(input logic [1:0] sel, input logic b, input logic [15:0] n);
    clrp_cmd_t c;
    c = '{sel: sel, rw: RW_BOTH, mode: MODE_RATE, bcd: b};
    host.wr(OFS_CMD, c);
    host.wr(port(sel), n[7:0]);
    host.wr(port(sel), n[15:8]);
  endtask : load

  task automatic latch(input logic [1:0] sel);
    host.wr(OFS_CMD, {sel, RW_LATCH, 4'h0});
  endtask : latch

  task automatic rd16(input logic [ADDR_W-1:0] a, input logic [15:0] e);
    host.rd(a, lo);
    host.rd(a, hi);
    `CHK({hi, lo}, e)
  endtask : rd16

  task automatic wrap_up();
    if (err_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(negedge clk_sys);
    `CHK(rdata, 8'h00)
    `CHK(cnt_out, 2'b11)
    `CHK(upd, 2'b00)
    rst = 1'b0;
    // Counting goes on behind each latch, so a live value would differ.
    foreach (rows[i]) begin
      load(rows[i].sel, rows[i].bcd, rows[i].n);
      ticks(rows[i].tk);
      latch(rows[i].sel);
      ticks(2);
      rd16(port(rows[i].sel), rows[i].e);
    end
    // Count latched before status, a repeat latch ignored, status still first.
    load(SEL_C1, 1'b0, 16'h0200);
    ticks(2);
    latch(SEL_C1);
    ticks(1);
    host.wr(OFS_CMD, 8'hE2);
    latch(SEL_C1);
    ticks(1);
    host.rd(OFS_CNT1, lo);
    `CHK(lo, 8'hB4)
    rd16(OFS_CNT1, 16'h01FF);
    rd16(OFS_CNT1, 16'h01FD);
    // Group two hides both ports; the ignored writes must not reload.
    grp_two = 1'b1;
    host.rd(OFS_CNT1, lo);
    `CHK(lo, BYTE_ZERO)
    host.rd(OFS_CNT2, lo);
    `CHK(lo, BYTE_ZERO)
    host.wr(OFS_CNT1, 8'h55);
    host.wr(OFS_CNT1, 8'h55);
    grp_two = 1'b0;
    ticks(1);
    rd16(OFS_CNT1, 16'h01FC);
    host.rd(4'hA, lo);
    `CHK(lo, BYTE_ZERO)
    host.rd(OFS_CMD, lo);
    `CHK(lo, BYTE_ZERO)
    // Rate of three: seven ticks give two rises on each output.
    load(SEL_C1, 1'b0, 16'h0003);
    load(SEL_C2, 1'b0, 16'h0003);
    ce = 1'b0;
    repeat (4) @(negedge clk_sys);
    ce = 1'b1;
    base = strobes;
    ticks(7);
    `CHK(strobes[0] - base[0], 2)
    `CHK(strobes[1] - base[1], 2)
    // Counter three at rate two feeds counter one one tick per two timebase ticks.
    load(SEL_C3, 1'b0, 16'h0002);
    alt_sel = 1'b1;
    repeat (4) @(negedge clk_sys);
    load(SEL_C1, 1'b0, 16'h0010);
    ticks(5);
    latch(SEL_C1);
    rd16(OFS_CNT1, 16'h000F);
    alt_sel = 1'b0;
    // Terminal count mode, high byte only: the output drops at load and stays low while counting.
    host.wr(OFS_CMD, 8'h60);
    host.wr(OFS_CNT2, 8'h02);
    ticks(2);
    host.rd(OFS_CNT2, lo);
    `CHK(lo, 8'h01)
    `CHK(cnt_out, 2'b01)
    // Square wave, low byte only: the first reload at one turns the output low.
    host.wr(OFS_CMD, 8'h16);
    host.wr(OFS_CNT1, 8'h02);
    ticks(3);
    host.rd(OFS_CNT1, lo);
    `CHK(lo, 8'h02)
    `CHK(cnt_out, 2'b00)
    // A second reset in mid-run returns the idle state.
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK(rdata, 8'h00)
    `CHK(cnt_out, 2'b11)
    `CHK(upd, 2'b00)
    rst = 1'b0;
    host.rd(OFS_CNT1, lo);
    `CHK(lo, 8'h00)
    wrap_up();
  end
endmodule : test_counter_load_readback_port
